/* i2c_master_transmitter.sv */
// two-wire bus master transmitter with avalon-mm register slave
`default_nettype none
module i2c_master_transmitter #(
  parameter int QUARTER = i2c_mt_pkg::QUARTER_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic irq,
  output logic master_receive_mode
);
  // control fields
  logic flag_reg;
  logic ack_en_reg;
  logic start_reg;
  logic stop_reg;
  logic wcol_reg;
  logic enable_reg;
  logic irq_en_reg;
  logic [7:0] shift_data_reg;
  logic [7:0] status_reg;
  // bus-side state
  i2c_mt_pkg::engine_state_e state_reg;
  logic [1:0] phase_reg;
  logic [2:0] bit_reg;
  logic master_reg;
  logic addr_phase_reg;
  logic lost_reg;
  logic ack_reg;
  logic rx_mode_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic busy_reg;
  logic sda_prev_reg;
  // bus slave
  logic [31:0] readdata_reg;
  logic read_ack_reg;

  wire [1:0] lines_s;
  wire scl_s = lines_s[1];
  wire sda_s = lines_s[0];
  wire tick;

  // ack status after the ninth bit of the address or a data byte
  function automatic logic [7:0] ack_status(input logic addr, input logic rd, input logic ack);
    logic [7:0] code;
    code = ack ? i2c_mt_pkg::ST_DATA_ACK : i2c_mt_pkg::ST_DATA_NACK;
    if (addr & ~rd) begin
      code = ack ? i2c_mt_pkg::ST_SLAW_ACK : i2c_mt_pkg::ST_SLAW_NACK;
    end else if (addr & rd) begin
      code = ack ? i2c_mt_pkg::ST_SLAR_ACK : i2c_mt_pkg::ST_SLAR_NACK;
    end
    return code;
  endfunction

  line_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in({scl_in, sda_in}),
    .sync_out(lines_s)
  );

  // the divider only runs while the engine is moving bits
  wire engine_run = (state_reg != i2c_mt_pkg::S_IDLE) & (state_reg != i2c_mt_pkg::S_HOLD);

  quarter_tick #(
    .COUNT(QUARTER)
  ) u_tick (
    .clk(clk),
    .reset(reset),
    .run(engine_run),
    .tick(tick)
  );

  // register decode
  wire wr_ctrl = avs_write & (avs_address == i2c_mt_pkg::CTRL_OFFSET);
  wire wr_data = avs_write & (avs_address == i2c_mt_pkg::DATA_OFFSET);
  wire wd_flag = avs_writedata[i2c_mt_pkg::BIT_FLAG];
  wire wd_start = avs_writedata[i2c_mt_pkg::BIT_START];
  wire wd_stop = avs_writedata[i2c_mt_pkg::BIT_STOP];
  wire wd_enable = avs_writedata[i2c_mt_pkg::BIT_ENABLE];
  wire [7:0] ctrl_value = {flag_reg, ack_en_reg, start_reg, stop_reg, wcol_reg, enable_reg,
                           1'b0, irq_en_reg};
  wire [7:0] read_mux = (avs_address == i2c_mt_pkg::CTRL_OFFSET) ? ctrl_value :
                        (avs_address == i2c_mt_pkg::STATUS_OFFSET) ? status_reg :
                        (avs_address == i2c_mt_pkg::DATA_OFFSET) ? shift_data_reg : 8'h00;

  // flag clear with enable set lets a suspended transfer go on
  wire resume = (state_reg == i2c_mt_pkg::S_HOLD) & wr_ctrl & wd_flag & wd_enable & flag_reg;

  // bus monitor: start and stop seen by anyone on the wire
  wire start_seen = scl_s & sda_prev_reg & ~sda_s;
  wire stop_seen = scl_s & ~sda_prev_reg & sda_s;
  wire bus_free = ~busy_reg & scl_s & sda_s;
  wire start_ok = master_reg | bus_free;

  // phase 2 waits for scl high, which also honours a slave stretching the clock
  wire phase_wait = (phase_reg == 2'd2) &
                    (~scl_s | ((state_reg == i2c_mt_pkg::S_START) & ~start_ok));
  wire step = tick & ~phase_wait;
  wire tx_bit = shift_data_reg[bit_reg];
  wire arb_lost = step & (state_reg == i2c_mt_pkg::S_BIT) & (phase_reg == 2'd2) &
                  ~sda_oe_reg & ~sda_s;
  wire event_done = step & (phase_reg == 2'd3) &
                    ((state_reg == i2c_mt_pkg::S_START) | (state_reg == i2c_mt_pkg::S_ACK));
  wire set_flag = event_done | arb_lost;
  wire stop_done = step & (phase_reg == 2'd3) & (state_reg == i2c_mt_pkg::S_STOP);

  // avalon: writes complete at once, reads after one wait cycle
  assign avs_waitrequest = avs_read & ~read_ack_reg;
  assign avs_readdata = readdata_reg;
  assign irq = flag_reg & irq_en_reg; // [RL23]
  assign master_receive_mode = rx_mode_reg;
  // open drain: only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_oe_reg;
  assign sda_oe = sda_oe_reg;

  // read path, status keeps its low bits at zero so masking is harmless
  always_ff @(posedge clk) begin
    if (reset) begin
      read_ack_reg <= 1'b0;
      readdata_reg <= i2c_mt_pkg::READ_IDLE;
    end else begin
      read_ack_reg <= avs_read & ~read_ack_reg;
      readdata_reg <= {24'h00_0000, read_mux}; // [RL21]
    end
  end

  // completion flag: hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (reset) begin
      flag_reg <= 1'b0;
    end else if (set_flag) begin
      flag_reg <= 1'b1; // [RL22] [RL3] [RL5]
    end else if (wr_ctrl & wd_flag) begin
      flag_reg <= 1'b0; // [RL22]
    end
  end

  // plain control fields; stop request also clears itself once sent
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_en_reg <= 1'b0;
      start_reg <= 1'b0;
      stop_reg <= 1'b0;
      enable_reg <= 1'b0;
      irq_en_reg <= 1'b0;
    end else if (wr_ctrl) begin
      ack_en_reg <= avs_writedata[i2c_mt_pkg::BIT_ACK_EN];
      start_reg <= wd_start;
      stop_reg <= wd_stop;
      enable_reg <= wd_enable;
      irq_en_reg <= avs_writedata[i2c_mt_pkg::BIT_IRQ_EN];
    end else if (stop_done) begin
      stop_reg <= 1'b0; // [RL16] [RL17]
    end
  end

  // data register: a load only lands while the flag is high
  always_ff @(posedge clk) begin
    if (reset) begin
      shift_data_reg <= i2c_mt_pkg::DATA_RESET;
      wcol_reg <= 1'b0;
    end else if (wr_data & flag_reg) begin
      shift_data_reg <= avs_writedata[7:0]; // [RL6]
      wcol_reg <= 1'b0;
    end else if (wr_data) begin
      wcol_reg <= 1'b1; // [RL7]
    end
  end

  // bus busy tracking from conditions seen on the wire
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_reg <= 1'b0;
      sda_prev_reg <= 1'b1;
    end else begin
      sda_prev_reg <= sda_s;
      if (start_seen) begin
        busy_reg <= 1'b1;
      end else if (stop_seen) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // bus engine; dropping the enable abandons any transfer and frees the lines
  always_ff @(posedge clk) begin
    if (reset | ~enable_reg) begin
      state_reg <= i2c_mt_pkg::S_IDLE;
      phase_reg <= 2'd0;
      bit_reg <= 3'd7;
      master_reg <= 1'b0;
      addr_phase_reg <= 1'b0;
      lost_reg <= 1'b0;
      ack_reg <= 1'b0;
      rx_mode_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      status_reg <= i2c_mt_pkg::ST_NO_INFO;
    end else begin
      if (step) begin
        phase_reg <= phase_reg + 2'd1;
      end
      case (state_reg)
        i2c_mt_pkg::S_IDLE: begin
          // a pending start request begins a transfer
          if (start_reg & ~flag_reg) begin
            state_reg <= i2c_mt_pkg::S_START; // [RL1] [RL2]
            phase_reg <= 2'd0;
            rx_mode_reg <= 1'b0;
          end
        end
        i2c_mt_pkg::S_HOLD: begin
          // nothing moves on the wire until software clears the flag
          if (resume) begin // [RL20]
            phase_reg <= 2'd0;
            lost_reg <= 1'b0;
            status_reg <= i2c_mt_pkg::ST_NO_INFO;
            if (wd_stop & master_reg) begin
              state_reg <= i2c_mt_pkg::S_STOP; // [RL10] [RL17]
            end else if (wd_start) begin
              state_reg <= i2c_mt_pkg::S_START; // [RL11] [RL19]
            end else if (lost_reg | ~master_reg) begin
              state_reg <= i2c_mt_pkg::S_IDLE; // [RL18]
            end else if (rx_mode_reg) begin
              state_reg <= i2c_mt_pkg::S_IDLE; // [RL13]
            end else begin
              state_reg <= i2c_mt_pkg::S_BIT; // [RL4] [RL8] [RL15] [RL9]
              bit_reg <= 3'd7;
            end
          end
        end
        i2c_mt_pkg::S_START: begin
          // release sda, release scl, pull sda while scl high, pull scl
          if (step) begin
            case (phase_reg)
              2'd0: sda_oe_reg <= 1'b0;
              2'd1: scl_oe_reg <= 1'b0;
              2'd2: sda_oe_reg <= 1'b1; // [RL2]
              default: begin
                scl_oe_reg <= 1'b1;
                status_reg <= master_reg ? i2c_mt_pkg::ST_RSTART : i2c_mt_pkg::ST_START; // [RL3] [RL12]
                master_reg <= 1'b1;
                addr_phase_reg <= 1'b1;
                rx_mode_reg <= 1'b0;
                state_reg <= i2c_mt_pkg::S_HOLD;
              end
            endcase
          end
        end
        i2c_mt_pkg::S_BIT: begin
          // msb first; sda only changes while scl is low
          if (arb_lost) begin
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            master_reg <= 1'b0;
            lost_reg <= 1'b1;
            status_reg <= i2c_mt_pkg::ST_ARB_LOST; // [RL18] [RL5]
            state_reg <= i2c_mt_pkg::S_HOLD;
          end else if (step) begin
            case (phase_reg)
              2'd0: sda_oe_reg <= ~tx_bit;
              2'd1: scl_oe_reg <= 1'b0;
              2'd2: sda_oe_reg <= sda_oe_reg;
              default: begin
                scl_oe_reg <= 1'b1;
                bit_reg <= bit_reg - 3'd1;
                if (bit_reg == 3'd0) begin
                  state_reg <= i2c_mt_pkg::S_ACK;
                end
              end
            endcase
          end
        end
        i2c_mt_pkg::S_ACK: begin
          // release sda and sample the receiver's answer with scl high
          if (step) begin
            case (phase_reg)
              2'd0: sda_oe_reg <= 1'b0;
              2'd1: scl_oe_reg <= 1'b0;
              2'd2: ack_reg <= ~sda_s;
              default: begin
                scl_oe_reg <= 1'b1;
                status_reg <= ack_status(addr_phase_reg, shift_data_reg[0], ack_reg); // [RL5] [RL14]
                rx_mode_reg <= addr_phase_reg & shift_data_reg[0]; // [RL13] [RL12]
                addr_phase_reg <= 1'b0;
                state_reg <= i2c_mt_pkg::S_HOLD;
              end
            endcase
          end
        end
        i2c_mt_pkg::S_STOP: begin
          // pull sda, release scl, release sda while scl high
          if (step) begin
            case (phase_reg)
              2'd0: sda_oe_reg <= 1'b1;
              2'd1: scl_oe_reg <= 1'b0;
              2'd2: sda_oe_reg <= 1'b0; // [RL10] [RL16]
              default: begin
                master_reg <= 1'b0;
                // start still requested: compete for the bus again
                state_reg <= start_reg ? i2c_mt_pkg::S_START : i2c_mt_pkg::S_IDLE; // [RL17]
              end
            endcase
          end
        end
        default: begin
          state_reg <= i2c_mt_pkg::S_IDLE;
          scl_oe_reg <= 1'b0;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* i2c_mt_asserts.sv */
// concurrent checks on the master transmitter ports
`default_nettype none
module i2c_mt_asserts #(
  parameter int QUARTER = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIM = 4 * QUARTER;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // control writes decide every change of the flag while suspended
  wire logic ctl_wr = avs_write && avs_address == i2c_mt_pkg::CTRL_OFFSET;
  wire logic mapped = avs_address inside {i2c_mt_pkg::CTRL_OFFSET, i2c_mt_pkg::STATUS_OFFSET,
    i2c_mt_pkg::DATA_OFFSET};
  a_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read answer not after one wait cycle");
  a_write_nowait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  a_flag_holds: assert property (irq && !ctl_wr |=> irq)
    else $error("flag dropped without a control write");
  a_flag_clear: assert property (irq && ctl_wr && avs_writedata[7] |=> !irq)
    else $error("writing one did not clear the flag");
  a_lines_frozen: assert property (irq && !ctl_wr |=> $stable(scl_oe) && $stable(sda_oe))
    else $error("bus lines moved while suspended");
  a_start_flag: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:LIM] (irq && scl_oe))
    else $error("start condition not followed by flag");
  a_stop_noflag: assert property ($fell(sda_oe) && !scl_oe && !$past(scl_oe) |-> !irq [*4])
    else $error("flag raised at stop condition");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && !mapped |-> avs_readdata == 0)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

/* i2c_mt_pkg.sv */
// shared constants, field layout and state codes of the master transmitter
`default_nettype none
// Notes on behaviour
// [RL1] software starts with start, enable, flag-clear write
// [RL2] start condition waits until bus is free
// [RL3] after start: flag set, status 0x08
// [RL4] software loads address+write, then clears flag
// [RL5] after address ack sampled: flag, 0x18/0x20/0x38
// [RL6] software writes data only while flag high
// [RL7] data write with flag low: ignored, collision set
// [RL8] software loads byte, clears flag to send
// [RL9] software ends transfer with stop or restart
// [RL10] flag-clear with stop request sends stop
// [RL11] flag-clear with start request sends repeated start
// [RL12] repeated start reports 0x10, keeps the bus
// [RL13] in 0x10, read bit switches to master receive
// [RL14] data byte sent: 0x28 on ack, 0x30 otherwise
// [RL15] plain flag-clear in data states sends byte
// [RL16] stop sent, then stop request self-clears
// [RL17] start plus stop: stop, then start, stop clears
// [RL18] arbitration lost reports 0x38; clear releases bus
// [RL19] in 0x38, start request restarts when bus free
// [RL20] flag set holds the bus transfer suspended
// [RL21] software masks status with 0xF8
// [RL22] flag cleared by writing one, set by hardware
// [RL23] flag and irq enable raise interrupt request
package i2c_mt_pkg;
  // bit timing: one bit is four quarter phases
  localparam int CLK_PERIOD_NS = 10;
  localparam int QUARTER_BIT_NS = 2500;
  localparam int QUARTER_CYCLES = (QUARTER_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte addresses on the bus
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] DATA_OFFSET = 4'h8;

  // serial_bus_control field positions
  localparam int BIT_FLAG = 7;
  localparam int BIT_ACK_EN = 6;
  localparam int BIT_START = 5;
  localparam int BIT_STOP = 4;
  localparam int BIT_WCOL = 3;
  localparam int BIT_ENABLE = 2;
  localparam int BIT_IRQ_EN = 0;

  // values after reset
  localparam logic [7:0] DATA_RESET = 8'hFF;
  localparam logic [31:0] READ_IDLE = 32'h0000_0000;

  // status codes, low three bits always zero
  localparam logic [7:0] STATUS_MASK = 8'hF8;
  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_RSTART = 8'h10;
  localparam logic [7:0] ST_SLAW_ACK = 8'h18;
  localparam logic [7:0] ST_SLAW_NACK = 8'h20;
  localparam logic [7:0] ST_DATA_ACK = 8'h28;
  localparam logic [7:0] ST_DATA_NACK = 8'h30;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_SLAR_ACK = 8'h40;
  localparam logic [7:0] ST_SLAR_NACK = 8'h48;
  localparam logic [7:0] ST_NO_INFO = 8'hF8;

  // bus engine states
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_START = 6'h02,
    S_BIT = 6'h04,
    S_ACK = 6'h08,
    S_STOP = 6'h10,
    S_HOLD = 6'h20
  } engine_state_e;
endpackage
`default_nettype wire

/* line_sync.sv */
// two-flop synchroniser for the bus lines, idles high
`default_nettype none
module line_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* quarter_tick.sv */
// divider giving a one-cycle enable pulse every COUNT cycles
`default_nettype none
module quarter_tick #(
  parameter int COUNT = 250
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  output logic tick
);
  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);
  logic [CW-1:0] count_reg;

  // restart from zero whenever stopped, so each phase is a full quarter
  always_ff @(posedge clk) begin
    if (reset | ~run) begin
      count_reg <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (count_reg == LAST);
      count_reg <= (count_reg == LAST) ? '0 : count_reg + CW'(1);
    end
  end
endmodule
`default_nettype wire

/* slave_rx_model.sv */
// behavioural slave receiver on the two-wire bus
`default_nettype none
module slave_rx_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_on,
  output logic sda_pull,
  output logic [7:0] last_byte,
  output int starts,
  output int stops
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'h00;
  int cnt = 9; // 9 means no frame yet, so power-up edges are ignored
  initial begin
    sda_pull = 1'b0;
    last_byte = 8'h00;
    starts = 0;
    stops = 0;
  end
  // start and stop are sda edges while scl is high
  always @(negedge sda) if (scl === 1'b1) begin
    starts++;
    cnt = 0;
    sda_pull = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) stops++;
  // msb first, ninth clock is the acknowledge slot
  always @(posedge scl) if (cnt == 8) cnt = 0;
  else if (cnt < 8) begin
    sh = {sh[6:0], sda};
    cnt++;
    if (cnt == 8) last_byte = sh;
  end
  // released line reads high through the pull-up
  always @(negedge scl) sda_pull = ack_on && cnt == 8;
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench for the master transmitter
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] CTL = i2c_mt_pkg::CTRL_OFFSET;
  localparam logic [3:0] STS = i2c_mt_pkg::STATUS_OFFSET;
  localparam logic [3:0] DAT = i2c_mt_pkg::DATA_OFFSET;
  logic clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, ack_on = 1'b1, tb_pull = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000, rdata, avs_readdata;
  logic avs_waitrequest, scl_oe, sda_oe, irq, mrm, sl_pull, scl_o, sda_o;
  logic [7:0] last_byte;
  int sl_starts, sl_stops, s0, bad_count = 0, checked = 0;
  // open-drain wires: any party pulling wins, otherwise the pull-up
  wire logic scl_w = !scl_oe;
  wire logic sda_w = !(sda_oe || sl_pull || tb_pull);
  always #5 clk = ~clk;
  i2c_master_transmitter #(.QUARTER(4)) uut (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_w),
    .scl_out(scl_o), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_o), .sda_oe(sda_oe), .irq(irq),
    .master_receive_mode(mrm));
  slave_rx_model slave (.scl(scl_w), .sda(sda_w), .ack_on(ack_on), .sda_pull(sl_pull),
    .last_byte(last_byte), .starts(sl_starts), .stops(sl_stops));
  task stop_test;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] fl(input logic b);
    return {31'h0000_0000, b};
  endfunction
  // one avalon transfer, held until waitrequest is sampled low
  task bus(input logic rd, input logic [3:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= {24'h00_0000, d};
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b0, a, d);
  endtask
  task rchk(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b1, a, 8'h00);
    chk(rdata, {24'h00_0000, exp});
  endtask
  task wait_flag;
    while (irq !== 1'b1) begin
      @(posedge clk);
    end
  endtask
  task send(input logic [7:0] b, input logic ack, input logic [7:0] st);
    ack_on <= ack;
    wr(DAT, b);
    wr(CTL, 8'h85);
    wait_flag;
    rchk(STS, st);
    chk({24'h00_0000, last_byte}, {24'h00_0000, b});
  endtask
  task t_idle;
    rchk(STS, 8'hF8);
    rchk(DAT, 8'hFF);
    rchk(4'hC, 8'h00);
    chk(fl(irq), 32'h0000_0000);
    chk({30'h0000_0000, sda_o, scl_o}, 32'h0000_0000);
  endtask
  task t_collide;
    wr(DAT, 8'h33);
    bus(1'b1, CTL, 8'h00);
    chk(rdata & 32'h0000_0008, 32'h0000_0008);
    rchk(DAT, 8'hFF);
  endtask
  task t_start;
    wr(CTL, 8'hA5);
    wait_flag;
    rchk(STS, 8'h08);
    chk(rdata & 32'h0000_00F8, 32'h0000_0008);
    chk(fl(irq), 32'h0000_0001);
    wr(CTL, 8'h45);
    bus(1'b1, CTL, 8'h00);
    chk(rdata & 32'h0000_00C0, 32'h0000_00C0);
    wr(DAT, 8'hA0);
    bus(1'b1, CTL, 8'h00);
    chk(rdata & 32'h0000_0008, 32'h0000_0000);
  endtask
  task t_rstart;
    int s1;
    s0 = sl_stops;
    s1 = sl_starts;
    wr(CTL, 8'hA5);
    wait_flag;
    rchk(STS, 8'h10);
    chk(32'(sl_stops), 32'(s0));
    chk(32'(sl_starts), 32'(s1 + 1));
    send(8'hB2, 1'b0, 8'h20);
    chk(fl(mrm), 32'h0000_0000);
  endtask
  task t_stop;
    s0 = sl_stops;
    wr(CTL, 8'h95);
    while (sl_stops == s0) begin
      @(posedge clk);
    end
    repeat (20) @(posedge clk);
    bus(1'b1, CTL, 8'h00);
    chk(rdata & 32'h0000_0090, 32'h0000_0000);
    rchk(STS, 8'hF8);
  endtask
  task t_read;
    t_start;
    send(8'hA1, 1'b1, 8'h40);
    s0 = sl_stops;
    wr(CTL, 8'hB5);
    wait_flag;
    rchk(STS, 8'h08);
    chk(32'(sl_stops), 32'(s0 + 1));
    bus(1'b1, CTL, 8'h00);
    chk(rdata & 32'h0000_0010, 32'h0000_0000);
    send(8'hA1, 1'b1, 8'h40);
    wr(CTL, 8'h85);
    while (mrm !== 1'b1) begin
      @(posedge clk);
    end
    chk(fl(mrm), 32'h0000_0001);
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk(fl(mrm), 32'h0000_0000);
    rchk(STS, 8'hF8);
  endtask
  task t_arb;
    wr(CTL, 8'hA5);
    wait_flag;
    tb_pull <= 1'b1;
    // the slave never sees a whole byte here, so its last byte is not compared
    wr(DAT, 8'hA0);
    wr(CTL, 8'h85);
    wait_flag;
    rchk(STS, 8'h38);
    chk({30'h0000_0000, sda_oe, scl_oe}, 32'h0000_0000);
    wr(CTL, 8'hA5);
    repeat (40) @(posedge clk);
    chk(fl(irq), 32'h0000_0000);
    tb_pull <= 1'b0;
    wait_flag;
    rchk(STS, 8'h08);
    t_stop;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_idle;
    t_collide;
    t_start;
    send(8'hA0, 1'b1, 8'h18);
    send(8'h5A, 1'b1, 8'h28);
    send(8'h3C, 1'b0, 8'h30);
    send(8'h01, 1'b1, 8'h28);
    t_rstart;
    t_stop;
    t_read;
    t_arb;
    stop_test;
  end
  // cut a hang short well beyond the fewer than two thousand cycles the run needs
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    stop_test;
  end
endmodule
bind i2c_master_transmitter i2c_mt_asserts #(.QUARTER(QUARTER)) chk_i (.clk, .reset,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .scl_oe, .sda_oe, .irq);
`default_nettype wire
